/* File: design/asf_pkg.sv */
package asf_pkg;

  // Register byte offsets
  localparam logic [7:0] ASF_ADDR_IRQ_PIN_A_ROUTE = 8'h23;
  localparam logic [7:0] ASF_ADDR_IRQ_PIN_B_ROUTE = 8'h24;
  localparam logic [7:0] ASF_ADDR_CTRL       = 8'h25;
  localparam logic [7:0] ASF_ADDR_OUT_XL     = 8'h28;
  localparam logic [7:0] ASF_ADDR_OUT_XH     = 8'h29;
  localparam logic [7:0] ASF_ADDR_OUT_YL     = 8'h2A;
  localparam logic [7:0] ASF_ADDR_OUT_YH     = 8'h2B;
  localparam logic [7:0] ASF_ADDR_OUT_ZL     = 8'h2C;
  localparam logic [7:0] ASF_ADDR_OUT_ZH     = 8'h2D;
  localparam logic [7:0] ASF_ADDR_WATERMARK  = 8'h2E;
  localparam logic [7:0] ASF_ADDR_STATUS     = 8'h2F;
  localparam logic [7:0] ASF_ADDR_COUNT      = 8'h30;

  // Field positions
  localparam int unsigned ASF_CTRL_MODE_LSB  = 5;
  localparam int unsigned ASF_CTRL_MAG_BIT   = 3;
  localparam int unsigned ASF_ROUTE_WM_BIT   = 1;
  localparam int unsigned ASF_ROUTE_OVR_BIT  = 2;
  localparam int unsigned ASF_STAT_WM_BIT    = 7;
  localparam int unsigned ASF_STAT_OVR_BIT   = 6;
  localparam int unsigned ASF_STAT_CNT8_BIT  = 0;

  // Reset values
  localparam logic [7:0] ASF_RST_ROUTE       = 8'h00;
  localparam logic [7:0] ASF_RST_CTRL        = 8'h00;
  localparam logic [7:0] ASF_RST_WATERMARK   = 8'h00;

  // Buffer behaviour codes
  localparam logic [2:0] ASF_MODE_BYPASS     = 3'h0;
  localparam logic [2:0] ASF_MODE_STOP       = 3'h1;
  localparam logic [2:0] ASF_MODE_CONT_STOP  = 3'h3;
  localparam logic [2:0] ASF_MODE_BYP_CONT   = 3'h4;
  localparam logic [2:0] ASF_MODE_CONT       = 3'h6;

  // Geometry
  localparam int unsigned ASF_SW             = 14;
  localparam int unsigned ASF_AW             = 8;
  localparam int unsigned ASF_DEPTH          = 256;
  localparam logic [8:0]  ASF_FULL           = 9'h100;
  localparam logic [8:0]  ASF_EMPTY          = 9'h000;
  localparam logic [1:0]  ASF_MAG_LAST       = 2'h2;

  typedef struct packed {
    logic [13:0] x;
    logic [13:0] y;
    logic [13:0] z;
  } asf_row_s;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } asf_reg_req_s;

endpackage

/* File: design/asf_row_ram.sv */
`timescale 1ns/100ps
module asf_row_ram
  import asf_pkg::*;
(
  // Clock
  input  wire logic              clk_sys_i,
  // Write side
  input  wire logic              we_i,
  input  wire logic [ASF_AW-1:0] waddr_i,
  input  wire asf_row_s          wdata_i,
  // Read side
  input  wire logic [ASF_AW-1:0] raddr_i,
  output asf_row_s               rdata_o
);

  asf_row_s mem [ASF_DEPTH];

  // One row holds one sample of each axis, or three consecutive magnitude values
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];

endmodule

/* File: design/asf_mag_packer.sv */
`timescale 1ns/100ps
module asf_mag_packer
  import asf_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  // Magnitude stream
  input  wire logic              enable_i,
  input  wire logic              mag_valid_i,
  input  wire logic [ASF_SW-1:0] mag_i,
  // Packed rows
  output logic                   row_valid_o,
  output asf_row_s               row_o
);

  logic [1:0]        phase_r;
  logic [ASF_SW-1:0] m0_r;
  logic [ASF_SW-1:0] m1_r;
  logic              last_w;

  assign last_w = mag_valid_i & (phase_r == ASF_MAG_LAST);

  // Three consecutive values per row, 768 values in 256 rows
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_r     <= 2'h0;
      m0_r        <= '0;
      m1_r        <= '0;
      row_valid_o <= 1'b0;
      row_o       <= '0;
    end else if (!enable_i) begin
      phase_r     <= 2'h0;
      row_valid_o <= 1'b0;
    end else begin
      row_valid_o <= last_w;
      if (mag_valid_i) begin
        phase_r <= last_w ? 2'h0 : phase_r + 2'h1;
        if (phase_r == 2'h0) begin
          m0_r <= mag_i;
        end
        if (phase_r == 2'h1) begin
          m1_r <= mag_i;
        end
      end
      if (last_w) begin
        row_o <= '{x: m0_r, y: m1_r, z: mag_i};
      end
    end
  end

endmodule

/* File: design/asf_sample_fifo.sv */
`timescale 1ns/100ps
module asf_sample_fifo
  import asf_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  // Sensor sample path
  input  wire logic              sample_valid_i,
  input  wire asf_row_s          sample_i,
  input  wire logic              mag_valid_i,
  input  wire logic [ASF_SW-1:0] mag_i,
  input  wire logic              trigger_i,
  // Register access from the serial interface
  input  wire asf_reg_req_s      reg_req_i,
  output logic [7:0]             reg_rdata_o,
  output logic                   reg_rvalid_o,
  // Interrupt pins
  output logic                   irq_pin_a_o,
  output logic                   irq_pin_b_o
);

  // Software registers
  logic [7:0]        irq_pin_a_route_control_r;
  logic [7:0]        irq_pin_b_route_control_r;
  logic [7:0]        buffer_control_r;
  logic [7:0]        buffer_watermark_r;

  // Buffer state
  logic [ASF_AW-1:0] wr_ptr_r;
  logic [ASF_AW-1:0] rd_ptr_r;
  logic [8:0]        count_r;
  logic [8:0]        count_nxt;
  logic              overrun_flag_r;
  logic              watermark_flag_r;
  logic              trig_seen_r;
  asf_row_s          latest_r;

  // Decode wires
  logic              wr_route1_w;
  logic              wr_route2_w;
  logic              wr_ctrl_w;
  logic              wr_wm_w;
  logic              rd_last_w;
  logic [2:0]        buffer_behaviour_select;
  logic              magnitude_to_buffer;
  logic [7:0]        watermark_level;

  // Address hits
  logic              hit_route1_w;
  logic              hit_route2_w;
  logic              hit_ctrl_w;
  logic              hit_out_xl_w;
  logic              hit_out_xh_w;
  logic              hit_out_yl_w;
  logic              hit_out_yh_w;
  logic              hit_out_zl_w;
  logic              hit_out_zh_w;
  logic              hit_wm_w;
  logic              hit_status_w;
  logic              hit_count_w;

  // Behaviour wires
  logic              mode_bypass_w;
  logic              mode_stop_w;
  logic              mode_cont_w;
  logic              mode_cont_stop_w;
  logic              mode_byp_cont_w;
  logic              store_cont_w;
  logic              store_stop_w;
  logic              hold_clear_w;
  logic              full_w;
  logic              empty_w;
  logic              in_valid_w;
  asf_row_s          in_row_w;
  logic              push_w;
  logic              pop_w;
  logic              overwrite_w;
  logic              watermark_flag_nxt;
  logic              overrun_flag_nxt;
  logic              trig_seen_nxt;
  logic              irq_a_nxt;
  logic              irq_b_nxt;

  // Packer and storage wires
  logic              pk_valid_w;
  asf_row_s          pk_row_w;
  asf_row_s          head_row_w;
  asf_row_s          view_row_w;
  logic [7:0]        status_w;
  logic [7:0]        rd_mux_w;
  logic [7:0]        x_lo_w;
  logic [7:0]        x_hi_w;
  logic [7:0]        y_lo_w;
  logic [7:0]        y_hi_w;
  logic [7:0]        z_lo_w;
  logic [7:0]        z_hi_w;

  // Address hits
  assign hit_route1_w = (reg_req_i.addr == ASF_ADDR_IRQ_PIN_A_ROUTE);
  assign hit_route2_w = (reg_req_i.addr == ASF_ADDR_IRQ_PIN_B_ROUTE);
  assign hit_ctrl_w   = (reg_req_i.addr == ASF_ADDR_CTRL);
  assign hit_out_xl_w = (reg_req_i.addr == ASF_ADDR_OUT_XL);
  assign hit_out_xh_w = (reg_req_i.addr == ASF_ADDR_OUT_XH);
  assign hit_out_yl_w = (reg_req_i.addr == ASF_ADDR_OUT_YL);
  assign hit_out_yh_w = (reg_req_i.addr == ASF_ADDR_OUT_YH);
  assign hit_out_zl_w = (reg_req_i.addr == ASF_ADDR_OUT_ZL);
  assign hit_out_zh_w = (reg_req_i.addr == ASF_ADDR_OUT_ZH);
  assign hit_wm_w     = (reg_req_i.addr == ASF_ADDR_WATERMARK);
  assign hit_status_w = (reg_req_i.addr == ASF_ADDR_STATUS);
  assign hit_count_w  = (reg_req_i.addr == ASF_ADDR_COUNT);

  // Register decode
  assign wr_route1_w = reg_req_i.wr & hit_route1_w;
  assign wr_route2_w = reg_req_i.wr & hit_route2_w;
  assign wr_ctrl_w   = reg_req_i.wr & hit_ctrl_w;
  assign wr_wm_w     = reg_req_i.wr & hit_wm_w;
  assign rd_last_w   = reg_req_i.rd & hit_out_zh_w;

  // Control fields
  assign buffer_behaviour_select =
    buffer_control_r[ASF_CTRL_MODE_LSB +: 3];
  assign magnitude_to_buffer = buffer_control_r[ASF_CTRL_MAG_BIT];
  assign watermark_level     = buffer_watermark_r;

  // Mode decode; unlisted codes act as bypass
  assign mode_stop_w      = (buffer_behaviour_select == ASF_MODE_STOP);
  assign mode_cont_w      = (buffer_behaviour_select == ASF_MODE_CONT);
  assign mode_cont_stop_w = (buffer_behaviour_select == ASF_MODE_CONT_STOP);
  assign mode_byp_cont_w  = (buffer_behaviour_select == ASF_MODE_BYP_CONT);
  assign mode_bypass_w    = ~(mode_stop_w | mode_cont_w |
                              mode_cont_stop_w | mode_byp_cont_w);

  // Continuous storage selection
  assign store_cont_w = mode_cont_w |
                        (mode_cont_stop_w & ~trig_seen_r) |
                        (mode_byp_cont_w & trig_seen_r);

  // Stop-when-full storage selection
  assign store_stop_w = mode_stop_w | (mode_cont_stop_w & trig_seen_r);

  // Bypass keeps the buffer cleared
  assign hold_clear_w = mode_bypass_w | (mode_byp_cont_w & ~trig_seen_r);

  assign full_w  = (count_r == ASF_FULL);
  assign empty_w = (count_r == ASF_EMPTY);

  // Input row source
  assign in_valid_w = magnitude_to_buffer ? pk_valid_w : sample_valid_i;
  assign in_row_w   = magnitude_to_buffer ? pk_row_w : sample_i;

  // Pop on a read of the last data register
  assign pop_w = rd_last_w & ~empty_w & ~hold_clear_w;

  // Push gating; stop mode refuses when full unless a pop is in the same cycle
  assign push_w = in_valid_w &
                  (store_cont_w | (store_stop_w & (~full_w | pop_w)));

  // Full buffer in continuous storage drops the oldest row
  assign overwrite_w = push_w & full_w & ~pop_w;

  // Unread count update
  assign count_nxt =
    hold_clear_w                   ? ASF_EMPTY :
    (push_w & ~pop_w & ~overwrite_w) ? count_r + 9'h001 :
    (pop_w & ~push_w)              ? count_r - 9'h001 :
                                     count_r;

  // Watermark compare, zero level disables
  assign watermark_flag_nxt = (watermark_level != 8'h00) &
                              (count_nxt >= {1'b0, watermark_level});

  // Overrun set wins over clear by pop or bypass
  assign overrun_flag_nxt = overwrite_w |
                            (overrun_flag_r & ~pop_w & ~hold_clear_w);

  // Trigger latch, rearmed by any control register write; set wins
  assign trig_seen_nxt = trigger_i | (trig_seen_r & ~wr_ctrl_w);

  // Interrupt routing
  assign irq_a_nxt =
    (irq_pin_a_route_control_r[ASF_ROUTE_WM_BIT] & watermark_flag_r) |
    (irq_pin_a_route_control_r[ASF_ROUTE_OVR_BIT] & overrun_flag_r);
  assign irq_b_nxt =
    (irq_pin_b_route_control_r[ASF_ROUTE_WM_BIT] & watermark_flag_r) |
    (irq_pin_b_route_control_r[ASF_ROUTE_OVR_BIT] & overrun_flag_r);

  // Output view: head row, or newest sample when nothing is stored
  assign view_row_w = (hold_clear_w | empty_w) ? latest_r : head_row_w;

  // Status with count bit 8
  assign status_w = {watermark_flag_r, overrun_flag_r, 5'h00, count_r[8]};

  // Data bytes; 14-bit samples left justified in 16 bits
  assign x_lo_w = {view_row_w.x[5:0], 2'h0};
  assign x_hi_w = view_row_w.x[13:6];
  assign y_lo_w = {view_row_w.y[5:0], 2'h0};
  assign y_hi_w = view_row_w.y[13:6];
  assign z_lo_w = {view_row_w.z[5:0], 2'h0};
  assign z_hi_w = view_row_w.z[13:6];

  // Read selection; unmapped addresses read zero
  assign rd_mux_w =
    hit_route1_w ? irq_pin_a_route_control_r :
    hit_route2_w ? irq_pin_b_route_control_r :
    hit_ctrl_w   ? buffer_control_r :
    hit_out_xl_w ? x_lo_w :
    hit_out_xh_w ? x_hi_w :
    hit_out_yl_w ? y_lo_w :
    hit_out_yh_w ? y_hi_w :
    hit_out_zl_w ? z_lo_w :
    hit_out_zh_w ? z_hi_w :
    hit_wm_w     ? buffer_watermark_r :
    hit_status_w ? status_w :
    hit_count_w  ? count_r[7:0] :
                   8'h00;

  // Magnitude packer
  asf_mag_packer u_packer (
    .clk_sys_i   (clk_sys_i),
    .arst_n_i    (arst_n_i),
    .enable_i    (magnitude_to_buffer),
    .mag_valid_i (mag_valid_i),
    .mag_i       (mag_i),
    .row_valid_o (pk_valid_w),
    .row_o       (pk_row_w)
  );

  // Row storage
  asf_row_ram u_ram (
    .clk_sys_i (clk_sys_i),
    .we_i      (push_w),
    .waddr_i   (wr_ptr_r),
    .wdata_i   (in_row_w),
    .raddr_i   (rd_ptr_r),
    .rdata_o   (head_row_w)
  );

  // Software registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_pin_a_route_control_r <= ASF_RST_ROUTE;
      irq_pin_b_route_control_r <= ASF_RST_ROUTE;
      buffer_control_r     <= ASF_RST_CTRL;
      buffer_watermark_r   <= ASF_RST_WATERMARK;
    end else begin
      if (wr_route1_w) begin
        irq_pin_a_route_control_r <= reg_req_i.wdata;
      end
      if (wr_route2_w) begin
        irq_pin_b_route_control_r <= reg_req_i.wdata;
      end
      if (wr_ctrl_w) begin
        buffer_control_r <= reg_req_i.wdata;
      end
      if (wr_wm_w) begin
        buffer_watermark_r <= reg_req_i.wdata;
      end
    end
  end

  // Pointers and count; bypass resets both pointers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= ASF_EMPTY;
    end else if (hold_clear_w) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= ASF_EMPTY;
    end else begin
      count_r <= count_nxt;
      if (push_w) begin
        wr_ptr_r <= wr_ptr_r + 8'h01;
      end
      if (pop_w | overwrite_w) begin
        rd_ptr_r <= rd_ptr_r + 8'h01;
      end
    end
  end

  // Newest sample holder for bypass view
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latest_r <= '0;
    end else if (in_valid_w) begin
      latest_r <= in_row_w;
    end
  end

  // Flags and trigger latch
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      watermark_flag_r <= 1'b0;
      overrun_flag_r   <= 1'b0;
      trig_seen_r      <= 1'b0;
    end else begin
      watermark_flag_r <= watermark_flag_nxt;
      overrun_flag_r   <= overrun_flag_nxt;
      trig_seen_r      <= trig_seen_nxt;
    end
  end

  // Read response
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        reg_rdata_o <= rd_mux_w;
      end
    end
  end

  // Interrupt pins
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_pin_a_o <= 1'b0;
      irq_pin_b_o <= 1'b0;
    end else begin
      irq_pin_a_o <= irq_a_nxt;
      irq_pin_b_o <= irq_b_nxt;
    end
  end

endmodule

/* File: verif/asf_sample_fifo_props.sv */
`timescale 1ns/100ps
module asf_chk
  import asf_pkg::*;
(
  // Clock and reset
  input wire logic         clk_sys_i,
  input wire logic         arst_n_i,
  // Sample path
  input wire logic         sample_valid_i,
  input wire logic         mag_valid_i,
  // Register bus and pins
  input wire asf_reg_req_s reg_req_i,
  input wire logic [7:0]   reg_rdata_o,
  input wire logic         reg_rvalid_o,
  input wire logic         irq_pin_a_o,
  input wire logic         irq_pin_b_o
);
  logic [7:0]      ctrl_r, wm_r, ra_r, rb_r;
  wire logic       rd_w = reg_req_i.rd;
  wire logic [7:0] ad_w = reg_req_i.addr;
  wire logic       q_w  = !sample_valid_i && !mag_valid_i;
  // Shadow copies of written registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= 8'h00;
      wm_r   <= 8'h00;
      ra_r   <= 8'h00;
      rb_r   <= 8'h00;
    end else if (reg_req_i.wr) begin
      case (ad_w)
        ASF_ADDR_CTRL:       ctrl_r <= reg_req_i.wdata;
        ASF_ADDR_WATERMARK:  wm_r   <= reg_req_i.wdata;
        ASF_ADDR_IRQ_PIN_A_ROUTE: ra_r   <= reg_req_i.wdata;
        ASF_ADDR_IRQ_PIN_B_ROUTE: rb_r   <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence s_st_cnt;
    (rd_w && ad_w == ASF_ADDR_STATUS && q_w && $past(q_w)) ##1 q_w
      ##1 (rd_w && ad_w == ASF_ADDR_COUNT && q_w);
  endsequence
  sequence s_ctrl_wr_rd;
    (reg_req_i.wr && ad_w == ASF_ADDR_CTRL)
      ##2 (rd_w && ad_w == ASF_ADDR_CTRL);
  endsequence
  a_rvalid_after_rd: assert property (rd_w |=> reg_rvalid_o)
    else $error("rvalid missing");
  a_status_rsvd_zero: assert property
    (rd_w && ad_w == ASF_ADDR_STATUS |=> reg_rdata_o[5:1] == 5'h00)
    else $error("status reserved bits set");
  a_full_low_zero: assert property
    (s_st_cnt |-> (reg_rdata_o[0] |=> reg_rdata_o == 8'h00))
    else $error("full count low byte not zero");
  a_wm_zero_low: assert property
    (rd_w && ad_w == ASF_ADDR_STATUS && wm_r == 8'h00
     && $past(wm_r) == 8'h00 |=> !reg_rdata_o[7])
    else $error("watermark flag with zero level");
  a_bypass_empty: assert property
    (rd_w && ad_w == ASF_ADDR_COUNT && ctrl_r[7:5] == 3'h0
     && $past(ctrl_r[7:5]) == 3'h0 |=> reg_rdata_o == 8'h00)
    else $error("count not zero in bypass");
  a_irq_a_gated: assert property
    (ra_r[2:1] == 2'h0 && $past(ra_r[2:1]) == 2'h0 |-> !irq_pin_a_o)
    else $error("pin a high without routing");
  a_irq_b_gated: assert property
    (rb_r[2:1] == 2'h0 && $past(rb_r[2:1]) == 2'h0 |-> !irq_pin_b_o)
    else $error("pin b high without routing");
  a_mode_readback: assert property
    (s_ctrl_wr_rd |=> (reg_rdata_o & 8'hE8)
     == ($past(reg_req_i.wdata, 3) & 8'hE8))
    else $error("control readback differs");
endmodule
bind asf_sample_fifo asf_chk u_chk (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req_i),
  .sample_valid_i(sample_valid_i), .mag_valid_i(mag_valid_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .irq_pin_a_o(irq_pin_a_o), .irq_pin_b_o(irq_pin_b_o));

/* File: verif/asf_host_model.sv */
`timescale 1ns/100ps
module asf_host_model
  import asf_pkg::*;
(
  // Clock
  input  wire logic       clk_sys_i,
  // Register bus
  output asf_reg_req_s    reg_req_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  initial reg_req_o = '0;
  // Idle edge first keeps strobes apart
  task automatic acc(input logic [7:0] a, input logic w,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_i);
    #1;
    reg_req_o = '{a, w, !w, d};
    @(posedge clk_sys_i);
    #1;
    reg_req_o = '0;
    q = (w || reg_rvalid_i) ? reg_rdata_i : 'x;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    acc(a, 1'b0, 8'h00, q);
  endtask
  // Whole row, high z byte last
  task automatic pop(output asf_row_s r);
    logic [7:0] b [6];
    for (int i = 0; i < 6; i++)
      rd(ASF_ADDR_OUT_XL + 8'(i), b[i]);
    r = {b[1], b[0][7:2], b[3], b[2][7:2], b[5], b[4][7:2]};
  endtask
  task automatic count(output logic [8:0] n);
    logic [7:0] s, c;
    rd(ASF_ADDR_STATUS, s);
    rd(ASF_ADDR_COUNT, c);
    n = {s[0], c};
  endtask
endmodule

/* File: verif/tb_accel_sample_fifo.sv */
`timescale 1ns/100ps
module tb_accel_sample_fifo
  import asf_pkg::*;
;
  logic         clk_sys_i      = 1'b0;
  logic         arst_n_i       = 1'b0;
  logic         sample_valid_i = 1'b0;
  asf_row_s     sample_i       = '0;
  logic         mag_valid_i    = 1'b0;
  logic [13:0]  mag_i          = '0;
  logic         trigger_i      = 1'b0;
  asf_reg_req_s reg_req_i;
  logic [7:0]   reg_rdata_o, s;
  logic         reg_rvalid_o, irq_pin_a_o, irq_pin_b_o;
  int           error_cnt      = 0;
  int           checks_done    = 0;
  asf_row_s     r;
  logic [8:0]   n;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  asf_sample_fifo dut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .mag_valid_i(mag_valid_i),
    .mag_i(mag_i), .trigger_i(trigger_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .irq_pin_a_o(irq_pin_a_o), .irq_pin_b_o(irq_pin_b_o));
  asf_host_model host (
    .clk_sys_i(clk_sys_i), .reg_req_o(reg_req_i),
    .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));
  function automatic asf_row_s row(input int v);
    return {14'(v), 14'(v + 1), 14'(v + 2)};
  endfunction
  task automatic check(input logic [41:0] got, input logic [41:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic push(input int k, input int b);
    for (int i = 0; i < k; i++) begin
      sample_valid_i = 1'b1;
      sample_i = row(b + i);
      step();
    end
    sample_valid_i = 1'b0;
  endtask
  task automatic trig();
    trigger_i = 1'b1;
    step();
    trigger_i = 1'b0;
  endtask
  task automatic mode(input logic [2:0] m);
    host.wr(ASF_ADDR_CTRL, 8'h00);
    host.wr(ASF_ADDR_CTRL, {m, 5'h00});
  endtask
  task automatic cnt_is(input logic [8:0] e);
    host.count(n);
    check(42'(n), 42'(e));
  endtask
  task automatic t_byp();
    logic [7:0] a [7];
    a = '{ASF_ADDR_IRQ_PIN_A_ROUTE, ASF_ADDR_IRQ_PIN_B_ROUTE, ASF_ADDR_CTRL,
          ASF_ADDR_WATERMARK, ASF_ADDR_STATUS, ASF_ADDR_COUNT, 8'h40};
    host.wr(ASF_ADDR_COUNT, 8'h5A);
    host.wr(8'h40, 8'hFF);
    push(2, 500);
    foreach (a[i]) begin
      host.rd(a[i], s);
      check(42'(s), 42'(0));
    end
    host.pop(r);
    check(r, row(501));
    $display("reset and bypass done");
  endtask
  task automatic t_stop();
    mode(ASF_MODE_STOP);
    push(257, 0);
    cnt_is(9'h100);
    host.pop(r); // first row (row 0) is popped unchecked; the 257th row was refused
    cnt_is(9'h0FF);
    host.pop(r);
    check(r, row(1));
    host.rd(ASF_ADDR_STATUS, s);
    check(42'(s[6]), 42'(0));
    mode(ASF_MODE_STOP);
    cnt_is(9'h000);
    $display("stop mode done");
  endtask
  task automatic t_cont();
    host.wr(ASF_ADDR_IRQ_PIN_A_ROUTE, 8'h04);
    mode(ASF_MODE_CONT);
    push(258, 100);
    cnt_is(9'h100);
    host.rd(ASF_ADDR_STATUS, s);
    check(42'({s[6], irq_pin_a_o}), 42'(3));
    host.pop(r);
    check(r, row(102));
    host.wr(ASF_ADDR_IRQ_PIN_A_ROUTE, 8'h00);
    $display("continuous done");
  endtask
  task automatic t_wm();
    host.wr(ASF_ADDR_WATERMARK, 8'h03);
    host.wr(ASF_ADDR_IRQ_PIN_B_ROUTE, 8'h02);
    mode(ASF_MODE_CONT);
    push(2, 0);
    host.rd(ASF_ADDR_STATUS, s);
    check(42'({s[7], irq_pin_b_o}), 42'(0));
    push(1, 2);
    host.rd(ASF_ADDR_STATUS, s);
    check(42'({s[7], irq_pin_b_o}), 42'(3));
    host.wr(ASF_ADDR_WATERMARK, 8'h00);
    host.rd(ASF_ADDR_STATUS, s);
    check(42'({s[7], irq_pin_b_o}), 42'(0));
    host.wr(ASF_ADDR_IRQ_PIN_B_ROUTE, 8'h00);
    $display("watermark done");
  endtask
  task automatic t_trig();
    mode(ASF_MODE_CONT_STOP);
    push(260, 0);
    trig();
    push(5, 1000);
    cnt_is(9'h100);
    host.pop(r);
    check(r, row(4));
    mode(ASF_MODE_BYP_CONT);
    push(3, 0);
    cnt_is(9'h000);
    trig();
    push(2, 700);
    cnt_is(9'h002);
    host.pop(r);
    check(r, row(700));
    host.pop(r);
    check(r, row(701));
    cnt_is(9'h000);
    $display("trigger modes done");
  endtask
  task automatic t_mag();
    mode(ASF_MODE_BYPASS);
    host.wr(ASF_ADDR_CTRL, {ASF_MODE_CONT, 5'h08});
    host.rd(ASF_ADDR_CTRL, s);
    check(42'(s & 8'hE8), 42'({ASF_MODE_CONT, 5'h08}));
    for (int i = 1; i <= 6; i++) begin
      mag_valid_i = 1'b1;
      mag_i = 14'(i * 10);
      step();
    end
    mag_valid_i = 1'b0;
    cnt_is(9'h002);
    host.pop(r);
    check(r, {14'(10), 14'(20), 14'(30)});
    mode(ASF_MODE_BYPASS);
    $display("magnitude done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    #1;
    arst_n_i = 1'b1;
    t_byp();
    t_stop();
    t_cont();
    t_wm();
    t_trig();
    t_mag();
    wrap_up();
  end
  initial begin
    #500_000;
    error_cnt++;
    wrap_up();
  end
endmodule
